// File: iec_params.svh
// Notes on behaviour
// - edge bit 3: request 3 and timer F input
// - edge bit 2: request 2 falling/rising
// - edge bit 1: request 1 and timer C input
// - edge bit 0: decoder request line
// - enable one: 8-bit rw, resets zero
// - enable one bit 7 gates timer A
// - enable one bit 6 gates decoder serial
// - enable one bit 5 gates all wakeups
// - enable one bits 4-0 gate requests 4-0
// - enable two: bits 7-1 rw, resets zero
// - enable two bit 7 gates direct transition
// - enable two bit 6 gates adc done
// - enable two bit 5 reserved, stores value
// - enable two bit 4 gates timer G
// - enable two bit 3 gates timer F high
// - enable two bit 2 gates timer F low
// - enable two bit 1 gates timer C
// - enable two bit 0 reads zero
// - edge select bits 7-5 read one
// - flags sticky, cleared by writing zero
`ifndef IEC_PARAMS_SVH
`define IEC_PARAMS_SVH
`define IEC_ADDR_EDGE 8'hf2
`define IEC_ADDR_EN1 8'hf3
`define IEC_ADDR_EN2 8'hf4
`define IEC_ADDR_FLAG1 8'hf6
`define IEC_ADDR_FLAG2 8'hf7
`define IEC_ADDR_WAKE 8'hf9
`define IEC_EDGE_RST 5'h00
`define IEC_EDGE_RSVD 3'h7
`define IEC_EN2_MASK 8'hfe
`define IEC_FLAG1_RSVD 8'h20
`define IEC_FLAG2_MASK 8'hde
`endif

// File: iec_pkg.sv
package iec_pkg;
  typedef logic [7:0] iec_byte_t;
  typedef struct packed {
    logic [4:0] edge_sel;
    iec_byte_t en1;
    iec_byte_t en2;
    iec_byte_t flag1;
    iec_byte_t flag2;
    iec_byte_t wake;
    logic [6:0] sync1;
    logic [6:0] sync2;
    logic [6:0] prev;
    logic [7:0] wsync1;
    logic [7:0] wsync2;
    logic [7:0] wprev;
    iec_byte_t rdata;
    logic [10:0] irq;
    logic tf_edge;
    logic tc_edge;
  } iec_state_t;
endpackage

// File: iec_edge_enable.sv
`timescale 1ns/1ps
`include "iec_params.svh"
module iec_edge_enable (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [7:0] ADDR,
  input wire iec_pkg::iec_byte_t WDATA,
  input wire logic WR,
  input wire logic RD,
  output iec_pkg::iec_byte_t RDATA,
  // pins, active low: 4..1 external requests, 0 decoder request line
  input wire logic [4:0] EXT_REQ_N,
  input wire logic TIMER_F_EVENT_IN,
  input wire logic TIMER_C_EVENT_IN,
  input wire logic [7:0] WAKEUP_PIN_N,
  // one-cycle events from on-chip logic on CLK
  input wire logic TIMER_A_OVF,
  input wire logic DECODER_SERIAL_DONE,
  input wire logic DIRECT_TRANSITION,
  input wire logic ADC_DONE,
  input wire logic TIMER_G_EVENT,
  input wire logic TIMER_F_HIGH_EVENT,
  input wire logic TIMER_F_LOW_EVENT,
  input wire logic TIMER_C_EVENT,
  output logic [10:0] IRQ,
  output logic TIMER_F_EDGE,
  output logic TIMER_C_EDGE
);
  import iec_pkg::*;

  iec_state_t s_q, s_d;
  logic [6:0] hit;
  logic [7:0] whit;
  logic [7:0] rd;

  // selected edge between two synchronised samples
  function automatic logic edge_hit(input logic prev, input logic cur, input logic rise);
    edge_hit = rise ? (!prev && cur) : (prev && !cur);
  endfunction

  always_comb begin
    s_d = s_q;
    // bit 5 of the sample vectors carries timer F input, bit 6 timer C input
    s_d.sync1 = {TIMER_C_EVENT_IN, TIMER_F_EVENT_IN, EXT_REQ_N};
    s_d.sync2 = s_q.sync1;
    s_d.prev = s_q.sync2;
    s_d.wsync1 = WAKEUP_PIN_N;
    s_d.wsync2 = s_q.wsync1;
    s_d.wprev = s_q.wsync2;
    for (int i = 0; i < 5; i++) begin
      hit[i] = edge_hit(s_q.prev[i], s_q.sync2[i], s_q.edge_sel[i]);
    end
    hit[5] = edge_hit(s_q.prev[5], s_q.sync2[5], s_q.edge_sel[3]);
    hit[6] = edge_hit(s_q.prev[6], s_q.sync2[6], s_q.edge_sel[1]);
    s_d.tf_edge = hit[5];
    s_d.tc_edge = hit[6];
    for (int i = 0; i < 8; i++) begin
      whit[i] = s_q.wprev[i] && !s_q.wsync2[i];
    end
    // writes of 0 clear flags, writes of 1 leave them; a new event wins
    if (WR && ADDR == `IEC_ADDR_EDGE) begin
      s_d.edge_sel = WDATA[4:0];
    end else if (WR && ADDR == `IEC_ADDR_EN1) begin
      s_d.en1 = WDATA;
    end else if (WR && ADDR == `IEC_ADDR_EN2) begin
      s_d.en2 = WDATA & `IEC_EN2_MASK;
    end else if (WR && ADDR == `IEC_ADDR_FLAG1) begin
      s_d.flag1 = s_q.flag1 & (WDATA | `IEC_FLAG1_RSVD);
    end else if (WR && ADDR == `IEC_ADDR_FLAG2) begin
      s_d.flag2 = s_q.flag2 & WDATA;
    end else if (WR && ADDR == `IEC_ADDR_WAKE) begin
      s_d.wake = s_q.wake & WDATA;
    end
    s_d.flag1 = s_d.flag1 | {TIMER_A_OVF, DECODER_SERIAL_DONE, 1'b0, hit[4:0]};
    s_d.flag2 = (s_d.flag2 | {DIRECT_TRANSITION, ADC_DONE, 1'b0, TIMER_G_EVENT,
                 TIMER_F_HIGH_EVENT, TIMER_F_LOW_EVENT, TIMER_C_EVENT, 1'b0}) & `IEC_FLAG2_MASK;
    s_d.wake = s_d.wake | whit;
    if (RD) begin
      if (ADDR == `IEC_ADDR_EDGE) begin
        rd = {`IEC_EDGE_RSVD, s_q.edge_sel};
      end else if (ADDR == `IEC_ADDR_EN1) begin
        rd = s_q.en1;
      end else if (ADDR == `IEC_ADDR_EN2) begin
        rd = s_q.en2;
      end else if (ADDR == `IEC_ADDR_FLAG1) begin
        rd = s_q.flag1;
      end else if (ADDR == `IEC_ADDR_FLAG2) begin
        rd = s_q.flag2;
      end else if (ADDR == `IEC_ADDR_WAKE) begin
        rd = s_q.wake;
      end else begin
        rd = 8'h00;
      end
    end else begin
      rd = 8'h00;
    end
    s_d.rdata = rd;
    // request = flag and enable
    s_d.irq[0] = s_q.flag1[0] && s_q.en1[0];
    s_d.irq[1] = s_q.flag1[1] && s_q.en1[1];
    s_d.irq[2] = s_q.flag1[2] && s_q.en1[2];
    s_d.irq[3] = s_q.flag1[3] && s_q.en1[3];
    s_d.irq[4] = s_q.flag1[4] && s_q.en1[4];
    s_d.irq[5] = (|s_q.wake) && s_q.en1[5];
    s_d.irq[6] = s_q.flag1[6] && s_q.en1[6];
    s_d.irq[7] = s_q.flag1[7] && s_q.en1[7];
    s_d.irq[8] = s_q.flag2[1] && s_q.en2[1];
    s_d.irq[9] = (s_q.flag2[2] && s_q.en2[2]) || (s_q.flag2[3] && s_q.en2[3]);
    s_d.irq[10] = (s_q.flag2[4] && s_q.en2[4]) || (s_q.flag2[6] && s_q.en2[6])
                  || (s_q.flag2[7] && s_q.en2[7]);
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      s_q <= '0;
      s_q.sync1 <= 7'h7f;
      s_q.sync2 <= 7'h7f;
      s_q.prev <= 7'h7f;
      s_q.wsync1 <= 8'hff;
      s_q.wsync2 <= 8'hff;
      s_q.wprev <= 8'hff;
      s_q.edge_sel <= `IEC_EDGE_RST;
      s_q.flag1 <= `IEC_FLAG1_RSVD;
    end else begin
      s_q <= s_d;
    end
  end

  assign RDATA = s_q.rdata;
  assign IRQ = s_q.irq;
  assign TIMER_F_EDGE = s_q.tf_edge;
  assign TIMER_C_EDGE = s_q.tc_edge;
endmodule

// File: iec_edge_enable_props.sv
`timescale 1ns/1ps
module iec_edge_enable_props (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [7:0] ADDR,
  input wire iec_pkg::iec_byte_t WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire iec_pkg::iec_byte_t RDATA,
  input wire logic [4:0] EXT_REQ_N,
  input wire logic TIMER_F_EVENT_IN,
  input wire logic TIMER_C_EVENT_IN,
  input wire logic [10:0] IRQ,
  input wire logic TIMER_F_EDGE,
  input wire logic TIMER_C_EDGE
);
  import iec_pkg::*;
  logic [4:0] es_q;
  iec_byte_t e1_q;
  iec_byte_t e2_q;
  logic [2:0] g2;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      es_q <= 5'h00;
      e1_q <= 8'h00;
      e2_q <= 8'h00;
    end else if (WR) begin
      if (ADDR == 8'hf2) es_q <= WDATA[4:0];
      if (ADDR == 8'hf3) e1_q <= WDATA;
      if (ADDR == 8'hf4) e2_q <= WDATA;
    end
  end
  // shared enables of the grouped request lines
  assign g2 = {e2_q[7] | e2_q[6] | e2_q[4], e2_q[3] | e2_q[2], e2_q[1]};
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  sequence rd_at(logic [7:0] a);
    RD && ADDR == a;
  endsequence
  a_edge_read: assert property (rd_at(8'hf2) |=> RDATA == {3'h7, es_q}) else $error("edge read");
  a_en1_read: assert property (rd_at(8'hf3) |=> RDATA == e1_q) else $error("en1 read");
  a_en2_read: assert property (rd_at(8'hf4) |=> RDATA == (e2_q & 8'hfe)) else $error("en2 read");
  a_en2_low: assert property (rd_at(8'hf4) |=> !RDATA[0]) else $error("en2 bit0");
  a_gate_one: assert property ((IRQ[7:0] & ~e1_q & ~$past(e1_q)) == 8'h00) else $error("gate one");
  a_gate_two: assert property ((IRQ[10:8] & ~g2 & ~$past(g2)) == 3'h0) else $error("gate two");
  a_tf_dir: assert property (TIMER_F_EDGE |-> TIMER_F_EVENT_IN == es_q[3]) else $error("f edge");
  a_tc_dir: assert property (TIMER_C_EDGE |-> TIMER_C_EVENT_IN == es_q[1]) else $error("c edge");
endmodule

// File: iec_evt_model.sv
`timescale 1ns/1ps
module iec_evt_model (
  input wire logic clk,
  input wire logic [7:0] fire,
  output logic [7:0] evt
);
  // each source drives its event one clock after its fire bit, for as many clocks as fire is held
  always_ff @(posedge clk) begin
    evt <= fire;
  end
endmodule

// File: testbench.sv
`timescale 1ns/1ps
module testbench;
  import iec_pkg::*;
  logic CLK = 0, RST = 1, WR = 0, RD = 0, TF = 1, TC = 1;
  logic [7:0] ADDR = 8'h00, WN = 8'hff, fire = 8'h00, ev, r = 8'h5e;
  iec_byte_t WDATA = 8'h00, RDATA;
  logic [4:0] RQ = 5'h1f;
  logic [10:0] IRQ;
  int fail_count = 0, compares = 0, cyc = 0, tfc = 0, tcc = 0;
  logic tf_e, tc_e;
  always #50 CLK = ~CLK;
  iec_evt_model src_u (.clk(CLK), .fire(fire), .evt(ev));
  iec_edge_enable dut_u (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .EXT_REQ_N(RQ), .TIMER_F_EVENT_IN(TF), .TIMER_C_EVENT_IN(TC), .WAKEUP_PIN_N(WN), .TIMER_A_OVF(ev[0]),
    .DECODER_SERIAL_DONE(ev[1]), .DIRECT_TRANSITION(ev[2]), .ADC_DONE(ev[3]), .TIMER_G_EVENT(ev[4]),
    .TIMER_F_HIGH_EVENT(ev[5]), .TIMER_F_LOW_EVENT(ev[6]), .TIMER_C_EVENT(ev[7]), .IRQ(IRQ),
    .TIMER_F_EDGE(tf_e), .TIMER_C_EDGE(tc_e));
  // count edge pulses away from the launching edge
  always @(negedge CLK) begin
    if (tf_e === 1'b1) tfc++;
    if (tc_e === 1'b1) tcc++;
  end
  function automatic logic [7:0] lf(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [4:0] pin_irq(input logic [4:0] es, input logic fell);
    return fell ? ~es : 5'h1f;
  endfunction
  task automatic chk(input string n, input logic [10:0] e, input logic [10:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input iec_byte_t d);
    @(posedge CLK);
    WR <= 1;
    ADDR <= a;
    WDATA <= d;
    @(posedge CLK);
    WR <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge CLK);
    RD <= 1;
    ADDR <= a;
    @(posedge CLK);
    RD <= 0;
    #1 chk("rdata", 11'(e), 11'(RDATA));
  endtask
  task automatic irq(input logic [10:0] e);
    repeat (8) @(posedge CLK);
    #1 chk("irq", e, IRQ);
    @(posedge CLK);
  endtask
  task automatic results;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      results;
    end
  end
  initial begin
    repeat (5) @(posedge CLK);
    RST <= 0;
    rd(8'hf2, 8'he0);
    rd(8'hf3, 8'h00);
    rd(8'hf4, 8'h00);
    rd(8'hf0, 8'h00);
    repeat (6) begin
      r = lf(r);
      wr(8'hf2, r);
      rd(8'hf2, {3'h7, r[4:0]});
      wr(8'hf3, ~r);
      rd(8'hf3, ~r);
      wr(8'hf4, r);
      rd(8'hf4, r & 8'hfe);
    end
    $display("registers done");
    wr(8'hf3, 8'h3f);
    wr(8'hf2, 8'h0a);
    {RQ, TF, TC, WN} <= 15'h0000;
    irq({6'h01, pin_irq(5'h0a, 1)});
    {RQ, TF, TC} <= 7'h7f;
    irq({6'h01, pin_irq(5'h0a, 0)});
    wr(8'hf3, 8'hff);
    wr(8'hf4, 8'hde);
    fire <= 8'hff;
    @(posedge CLK);
    fire <= 8'h00;
    irq(11'h7ff);
    wr(8'hf4, 8'h20);
    irq(11'h0ff);
    wr(8'hf6, 8'hff);
    irq(11'h0ff);
    wr(8'hf6, 8'h00);
    wr(8'hf9, 8'h00);
    irq(11'h000);
    chk("tf edges", 11'h001, 11'(tfc));
    chk("tc edges", 11'h001, 11'(tcc));
    $display("events done");
    results;
  end
endmodule
bind iec_edge_enable iec_edge_enable_props chk_u (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
  .RD(RD), .RDATA(RDATA), .EXT_REQ_N(EXT_REQ_N), .TIMER_F_EVENT_IN(TIMER_F_EVENT_IN),
  .TIMER_C_EVENT_IN(TIMER_C_EVENT_IN), .IRQ(IRQ),
  .TIMER_F_EDGE(TIMER_F_EDGE), .TIMER_C_EDGE(TIMER_C_EDGE));
